// ---- pcid_regs.svh ----
`ifndef PCID_REGS_SVH
`define PCID_REGS_SVH

// Port index within a register group
`define PCID_PORT_A        2'd0
`define PCID_PORT_B        2'd1
`define PCID_PORT_C        2'd2
`define PCID_PORT_E        2'd3

// Per-port register byte addresses
`define PCID_RISE_A_OFF    12'h000
`define PCID_FALL_A_OFF    12'h004
`define PCID_FLAG_A_OFF    12'h008
`define PCID_RISE_B_OFF    12'h010
`define PCID_FALL_B_OFF    12'h014
`define PCID_FLAG_B_OFF    12'h018
`define PCID_RISE_C_OFF    12'h020
`define PCID_FALL_C_OFF    12'h024
`define PCID_FLAG_C_OFF    12'h028
`define PCID_RISE_E_OFF    12'h030
`define PCID_FALL_E_OFF    12'h034
`define PCID_FLAG_E_OFF    12'h038

// Control, summary and event status
`define PCID_CTRL_OFF      12'h040
`define PCID_SUMMARY_OFF   12'h044
`define PCID_EVT_STAT_OFF  12'h048
`define PCID_EVT_MASK_OFF  12'h04c

// Control and event status fields
`define PCID_CTRL_IRQ_EN   0
`define PCID_EVT_EDGE      0
`define PCID_EVT_WAKE      1

// Reset values
`define PCID_REG_RESET     8'h00
`define PCID_EVT_RESET     2'h0

// Port E carries only pin 3, which doubles as the reset pin
`define PCID_PORT_E_MASK   8'h08
`define PCID_RESET_PIN_BIT 3

`endif

// ---- pcid_pkg.sv ----
package pcid_pkg;
	typedef enum logic [1:0]
	{
		PCID_BUS_IDLE,
		PCID_BUS_WRITE,
		PCID_BUS_READ
	} pcid_bus_state_t;

	typedef logic [7:0] pcid_byte_t;
endpackage

// ---- pcid_pin_edge.sv ----
`timescale 1ns/100ps
`include "pcid_regs.svh"

module pcid_pin_edge
#(
	parameter int WIDTH = 8
)
(
	// System
	input  wire logic             clock,
	input  wire logic             rst,
	// Pins and enables
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic [WIDTH-1:0] rise_en,
	input  wire logic [WIDTH-1:0] fall_en,
	// One-cycle edge hits
	output      logic [WIDTH-1:0] edge_hit
);
	logic [WIDTH-1:0] sync1_reg;
	logic [WIDTH-1:0] sync2_reg;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] hit_reg;
	wire  [WIDTH-1:0] hit_next;

	// Sync, then compare current sample against previous one
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			// Preload with the pin level: an idle-high pin gives no
			// false edge once reset lets go
			sync1_reg <= pin_in;
			sync2_reg <= pin_in;
			prev_reg  <= pin_in;
			hit_reg   <= '0;
		end
		else
		begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			hit_reg   <= hit_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			// Rising falling both together give either
			assign hit_next[g] = (rise_en[g] & sync2_reg[g] & ~prev_reg[g])
				| (fall_en[g] & ~sync2_reg[g] & prev_reg[g]);
		end
	endgenerate

	assign edge_hit = hit_reg;
endmodule

// ---- pcid_bus_slave.sv ----
`timescale 1ns/100ps

module pcid_bus_slave
(
	// System
	input  wire logic        clock,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output      logic [31:0] hrdata,
	output      logic        hreadyout,
	output      logic        hresp,
	// Register side
	output      logic        wr_stb,
	output      logic        rd_stb,
	output      logic [11:0] reg_addr,
	output      logic [11:0] wr_addr,
	output      logic [7:0]  wr_data,
	input  wire logic [7:0]  rd_data
);
	pcid_pkg::pcid_bus_state_t state_reg;
	pcid_pkg::pcid_bus_state_t state_next;
	logic [11:0]               addr_reg;
	logic [31:0]               rdata_reg;
	wire                       take;

	// Single word transfers only; hsize is accepted but not checked
	assign take = hsel & hready & htrans[1];

	always_comb
	begin
		state_next = pcid_pkg::PCID_BUS_IDLE;
		if (take)
		begin
			if (hwrite)
				state_next = pcid_pkg::PCID_BUS_WRITE;
			else
				state_next = pcid_pkg::PCID_BUS_READ;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= pcid_pkg::PCID_BUS_IDLE;
			addr_reg  <= 12'h000;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			state_reg <= state_next;
			if (take)
				addr_reg <= haddr;
			if (state_next == pcid_pkg::PCID_BUS_READ)
				rdata_reg <= {24'h00_0000, rd_data};
		end
	end

	// Read sampled at the address phase so hrdata comes from a flop
	assign rd_stb    = take & ~hwrite;
	assign reg_addr  = rd_stb ? haddr : addr_reg;
	assign wr_stb    = (state_reg == pcid_pkg::PCID_BUS_WRITE);
	// Writes keep their own latched address, so a read address phase
	// may overlap a write data phase; such a read of the register just
	// written still returns its old value
	assign wr_addr   = addr_reg;
	assign wr_data   = hwdata[7:0];
	assign hrdata    = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule

// ---- pcid_top.sv ----
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "pcid_regs.svh"

module pcid_top
(
	// System
	input  wire logic        clock,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output      logic [31:0] hrdata,
	output      logic        hreadyout,
	output      logic        hresp,
	// Port pins, port D has no change detect
	input  wire logic [7:0]  port_a_in,
	input  wire logic [7:0]  port_b_in,
	input  wire logic [7:0]  port_c_in,
	input  wire logic [7:0]  port_e_in,
	// Configuration straps
	input  wire logic        ext_reset_pin_enable,
	input  wire logic        low_voltage_prog_enable,
	// Core interface
	input  wire logic        core_asleep,
	output      logic        change_irq_summary,
	output      logic        change_irq,
	output      logic        wake_req,
	output      logic        irq
);
	// ============================================================
	// Bus and register file
	// ============================================================
	logic        wr_stb;
	logic        rd_stb;
	logic [11:0] reg_addr;
	logic [11:0] wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;

	pcid_bus_slave u_bus
	(
		.clock     (clock),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_stb    (wr_stb),
		.rd_stb    (rd_stb),
		.reg_addr  (reg_addr),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.rd_data   (rd_data)
	);

	logic [7:0] rise_reg [4];
	logic [7:0] fall_reg [4];
	logic [7:0] flag_reg [4];
	logic [7:0] flag_next [4];
	logic [7:0] hit [4];
	logic [7:0] pin_mask [4];
	logic [7:0] pins [4];
	logic       ctrl_reg;
	logic [1:0] evt_stat_reg;
	logic [1:0] evt_mask_reg;
	logic [1:0] evt_stat_next;

	function automatic logic [2:0] port_of(input logic [11:0] a);
		port_of = {1'b0, a[5:4]};
		if (a[11:6] != 6'h00 || a[3:2] == 2'd3 || a[1:0] != 2'd0)
			port_of = 3'd4;
	endfunction

	wire [2:0] wr_port  = port_of(wr_addr);
	wire [1:0] wr_kind  = wr_addr[3:2];
	wire       any_hit  = |{hit[0], hit[1], hit[2], hit[3]};
	wire       rd_evt   = rd_stb && reg_addr == `PCID_EVT_STAT_OFF;

	assign pins[0] = port_a_in;
	assign pins[1] = port_b_in;
	assign pins[2] = port_c_in;
	assign pins[3] = port_e_in;

	// Reset pin loses change detect in reset or programming use
	assign pin_mask[0] = 8'hff;
	assign pin_mask[1] = 8'hff;
	assign pin_mask[2] = 8'hff;
	assign pin_mask[3] = (ext_reset_pin_enable | low_voltage_prog_enable)
		? 8'h00 : `PCID_PORT_E_MASK;

	// ============================================================
	// Detection per port
	// ============================================================
	// Four detector groups: A, B, C, E; port D has none
	genvar p;
	generate
		for (p = 0; p < 4; p++)
		begin : g_port
			wire wr_here = wr_stb && wr_port == 3'(p);

			pcid_pin_edge #(.WIDTH(8)) u_edge
			(
				.clock    (clock),
				.rst      (rst),
				.pin_in   (pins[p]),
				.rise_en  (rise_reg[p] & pin_mask[p]),
				.fall_en  (fall_reg[p] & pin_mask[p]),
				.edge_hit (hit[p])
			);

			// Written value loads flags; new hit wins
			// Detection ignores irq enable flags sticky
			assign flag_next[p] = ((wr_here && wr_kind == 2'd2)
				? (wr_data & pin_mask[p]) : flag_reg[p]) | hit[p];

			always_ff @(posedge clock)
			begin
				if (rst)
				begin
					rise_reg[p] <= `PCID_REG_RESET;
					fall_reg[p] <= `PCID_REG_RESET;
					flag_reg[p] <= `PCID_REG_RESET;
				end
				else
				begin
					if (wr_here && wr_kind == 2'd0)
						rise_reg[p] <= wr_data & pin_mask[p];
					if (wr_here && wr_kind == 2'd1)
						fall_reg[p] <= wr_data & pin_mask[p];
					flag_reg[p] <= flag_next[p];
				end
			end

			a_flag_sticky: assert property (
				@(posedge clock) disable iff (rst)
				$past(hit[p]) != 8'h00 |-> (flag_reg[p] & $past(hit[p]))
				== $past(hit[p])) else $error("edge hit lost");
		end
	endgenerate

	// ============================================================
	// Summary, wake, event status
	// ============================================================
	// Summary is pure OR of every flag; no write path exists
	assign change_irq_summary = |{flag_reg[0], flag_reg[1],
		flag_reg[2], flag_reg[3]};
	// Core request gated by enable only
	assign change_irq = change_irq_summary & ctrl_reg;
	// Hit lands in flag on the edge after wake rises, before any fetch
	assign wake_req = core_asleep & ctrl_reg & any_hit;

	// Hardware set wins over read-clear
	assign evt_stat_next = (rd_evt ? 2'b00 : evt_stat_reg)
		| {wake_req, any_hit};

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_reg     <= 1'b0;
			evt_stat_reg <= `PCID_EVT_RESET;
			evt_mask_reg <= `PCID_EVT_RESET;
		end
		else
		begin
			if (wr_stb && wr_addr == `PCID_CTRL_OFF)
				ctrl_reg <= wr_data[`PCID_CTRL_IRQ_EN];
			if (wr_stb && wr_addr == `PCID_EVT_MASK_OFF)
				evt_mask_reg <= wr_data[1:0];
			evt_stat_reg <= evt_stat_next;
		end
	end

	assign irq = |(evt_stat_reg & evt_mask_reg);

	// ============================================================
	// Read mux
	// ============================================================
	wire [2:0] rd_port = port_of(reg_addr);
	always_comb
	begin
		rd_data = 8'h00;
		if (rd_port != 3'd4)
		begin
			if (reg_addr[3:2] == 2'd0)
				rd_data = rise_reg[rd_port[1:0]];
			else if (reg_addr[3:2] == 2'd1)
				rd_data = fall_reg[rd_port[1:0]];
			else
				rd_data = flag_reg[rd_port[1:0]];
		end
		else if (reg_addr == `PCID_CTRL_OFF)
			rd_data = {7'h00, ctrl_reg};
		else if (reg_addr == `PCID_SUMMARY_OFF)
			rd_data = {7'h00, change_irq_summary};
		else if (reg_addr == `PCID_EVT_STAT_OFF)
			rd_data = {6'h00, evt_stat_reg};
		else if (reg_addr == `PCID_EVT_MASK_OFF)
			rd_data = {6'h00, evt_mask_reg};
	end

	// ============================================================
	// Checks
	// ============================================================
	// Pin A0 as the detector sees it, after the synchroniser
	wire u_edge_a_sync = g_port[0].u_edge.sync2_reg[0];

	// Enabled rise or fall of pin A0
	sequence s_rise_a0;
		$rose(u_edge_a_sync) && rise_reg[0][0];
	endsequence

	sequence s_fall_a0;
		$fell(u_edge_a_sync) && fall_reg[0][0];
	endsequence

	// One-cycle hit, then the sticky flag on the following edge
	sequence s_hit_flag_a0;
		hit[0][0] ##1 flag_reg[0][0];
	endsequence

	// Summary and request gating
	a_summary_or: assert property (
		@(posedge clock) disable iff (rst)
		change_irq_summary == ((flag_reg[0] | flag_reg[1] | flag_reg[2]
		| flag_reg[3]) != 8'h00)) else $error("summary mismatch");
	a_summary_ro: assert property (
		@(posedge clock) disable iff (rst)
		wr_stb && wr_addr == `PCID_SUMMARY_OFF && !any_hit
		|=> $stable(change_irq_summary)) else $error("summary written");
	a_irq_gate: assert property (
		@(posedge clock) disable iff (rst)
		change_irq |-> ctrl_reg && change_irq_summary)
		else $error("irq without enable");
	a_ctrl_load: assert property (
		@(posedge clock) disable iff (rst)
		wr_stb && wr_addr == `PCID_CTRL_OFF
		|=> {7'h00, ctrl_reg} == ($past(wr_data) & 8'h01))
		else $error("enable write lost");

	// Detector path on pin A0
	a_rise_a: assert property (
		@(posedge clock) disable iff (rst)
		s_rise_a0 |=> s_hit_flag_a0) else $error("rise missed");
	a_fall_a: assert property (
		@(posedge clock) disable iff (rst)
		s_fall_a0 |=> s_hit_flag_a0) else $error("fall missed");
	a_no_hit_off: assert property (
		@(posedge clock) disable iff (rst)
		!rise_reg[0][0] && !fall_reg[0][0] |=> !hit[0][0])
		else $error("hit while disabled");

	// Flag register writes
	a_flag_clear: assert property (
		@(posedge clock) disable iff (rst)
		wr_stb && wr_addr == `PCID_FLAG_A_OFF && hit[0] == 8'h00
		|=> flag_reg[0] == $past(wr_data)) else $error("flag write");
	a_flag_hold: assert property (
		@(posedge clock) disable iff (rst)
		flag_reg[1] != 8'h00 && !wr_stb |=> flag_reg[1] != 8'h00)
		else $error("flag dropped");

	// Sleep and wake
	a_wake_flag: assert property (
		@(posedge clock) disable iff (rst)
		wake_req |=> change_irq_summary) else $error("wake no flag");
	a_evt_wake: assert property (
		@(posedge clock) disable iff (rst)
		wake_req |=> evt_stat_reg[`PCID_EVT_WAKE])
		else $error("wake not recorded");

	// Reset-pin and port E masking
	a_rstpin_off: assert property (
		@(posedge clock) disable iff (rst)
		ext_reset_pin_enable && $past(ext_reset_pin_enable)
		|-> hit[3] == 8'h00) else $error("reset pin detect");
	a_lvprog_off: assert property (
		@(posedge clock) disable iff (rst)
		low_voltage_prog_enable && $past(low_voltage_prog_enable)
		|-> hit[3] == 8'h00) else $error("programming pin detect");
	a_port_e_bits: assert property (
		@(posedge clock) disable iff (rst)
		(hit[3] & ~`PCID_PORT_E_MASK) == 8'h00)
		else $error("port e extra bit");
endmodule

// ---- pcid_pin_model.sv ----
`timescale 1ns/100ps

// ==========================
// Port pins and core state
module pcid_pin_model
(
	// System
	input  wire logic       clock,
	// Pins and sleep state
	output      logic [7:0] port_a_in,
	output      logic [7:0] port_b_in,
	output      logic [7:0] port_c_in,
	output      logic [7:0] port_e_in,
	output      logic       core_asleep
);
	initial
	begin
		port_a_in = 8'h00;
		port_b_in = 8'h00;
		port_c_in = 8'h00;
		port_e_in = 8'h00;
		core_asleep = 1'b0;
	end

	// Levels move just after an edge; callers hold them >=2 clocks, except the one-clock port E low between the reset-pin and programming checks
	task automatic drive(input logic [1:0] p, input logic [7:0] v);
	begin
		@(posedge clock);
		case (p)
			2'd0: port_a_in <= v;
			2'd1: port_b_in <= v;
			2'd2: port_c_in <= v;
			default: port_e_in <= v;
		endcase
	end
	endtask

	task automatic doze(input logic s);
	begin
		@(posedge clock);
		core_asleep <= s;
	end
	endtask
endmodule

// ---- pcid_top_tb.sv ----
`timescale 1ns/100ps
`include "pcid_regs.svh"

module pcid_top_tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        ext_en = 1'b0;
	logic        lv_prog_en = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  pa, pb, pc, pe;
	logic        asleep, summ, cirq, wake, irq;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          wake_cnt = 0;
	int          w;

	initial
	begin
		forever #4 clock = ~clock;
	end

	pcid_pin_model pins
	(
		.clock(clock), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
		.port_e_in(pe), .core_asleep(asleep)
	);

	pcid_top DUT
	(
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .port_a_in(pa),
		.port_b_in(pb), .port_c_in(pc), .port_e_in(pe),
		.ext_reset_pin_enable(ext_en),
		.low_voltage_prog_enable(lv_prog_en),
		.core_asleep(asleep),
		.change_irq_summary(summ), .change_irq(cirq),
		.wake_req(wake), .irq(irq)
	);

	always @(posedge clock)
	begin
		if (wake === 1'b1)
			wake_cnt <= wake_cnt + 1;
	end

	// ==========================
	// Bus and check tasks
	task automatic summarize();
	begin
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
	begin
		cmp_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, s, e);
		end
	end
	endtask

	task automatic xfer(input logic [11:0] a, input logic wr,
		input logic [7:0] d, output logic [31:0] r);
	begin
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
	begin
		xfer(a, 1'b1, d, r);
	end
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] r;
	begin
		xfer(a, 1'b0, 8'h00, r);
		chk(r, {24'h0, e});
	end
	endtask

	function automatic logic [11:0] ra(input logic [1:0] p,
		input logic [3:0] o);
		return {6'h0, p, o};
	endfunction

	// Low pulse then rise on port A bit 0, long enough to be seen
	task automatic bump_a();
	begin
		pins.drive(2'd0, 8'h00);
		repeat (3) @(posedge clock);
		pins.drive(2'd0, 8'h01);
		repeat (8) @(posedge clock);
	end
	endtask

	// ==========================
	// Tests
	initial
	begin
		#100000;
		n_mismatch++;
		summarize();
	end

	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int p = 0; p < 4; p++)
			for (int o = 0; o < 12; o += 4)
				rd(ra(2'(p), 4'(o)), `PCID_REG_RESET);
		rd(`PCID_CTRL_OFF, 8'h00);
		rd(`PCID_EVT_MASK_OFF, 8'h00);
		rd(12'h100, 8'h00);
		chk(hresp, 1'b0);
		wr(ra(1, 4'h0), 8'h05);
		wr(ra(1, 4'h4), 8'h06);
		pins.drive(`PCID_PORT_B, 8'h07);
		repeat (8) @(posedge clock);
		rd(ra(1, 4'h8), 8'h05);
		chk(summ, 1'b1);
		chk(cirq, 1'b0);
		wr(ra(1, 4'h8), 8'h00);
		pins.drive(`PCID_PORT_B, 8'h00);
		repeat (8) @(posedge clock);
		rd(ra(1, 4'h8), 8'h06);
		wr(ra(0, 4'h8), 8'ha0);
		rd(ra(0, 4'h8), 8'ha0);
		wr(`PCID_SUMMARY_OFF, 8'h01);
		wr(ra(1, 4'h8), 8'h06 & ~8'h06);
		chk(summ, 1'b1);
		wr(ra(0, 4'h8), 8'h00);
		// Flag clear lands on the edge that ends the write; look after it
		@(posedge clock);
		chk(summ, 1'b0);
		rd(`PCID_SUMMARY_OFF, 8'h00);
		wr(`PCID_CTRL_OFF, 8'h01);
		wr(ra(2, 4'h0), 8'h80);
		pins.drive(`PCID_PORT_C, 8'h80);
		repeat (8) @(posedge clock);
		chk(cirq, 1'b1);
		wr(ra(2, 4'h8), 8'h00);
		wr(ra(0, 4'h0), 8'h01);
		// Write data phase meets the one-cycle hit of this rise
		pins.drive(`PCID_PORT_A, 8'h01);
		repeat (2) @(posedge clock);
		wr(ra(0, 4'h8), 8'h00);
		repeat (4) @(posedge clock);
		rd(ra(0, 4'h8), 8'h01);
		wr(ra(3, 4'h0), 8'hff);
		ext_en <= 1'b1;
		pins.drive(`PCID_PORT_E, 8'hff);
		repeat (8) @(posedge clock);
		rd(ra(3, 4'h8), 8'h00);
		pins.drive(`PCID_PORT_E, 8'h00);
		ext_en <= 1'b0;
		lv_prog_en <= 1'b1;
		pins.drive(`PCID_PORT_E, 8'hff);
		repeat (8) @(posedge clock);
		rd(ra(3, 4'h8), 8'h00);
		pins.drive(`PCID_PORT_E, 8'h00);
		lv_prog_en <= 1'b0;
		repeat (2) @(posedge clock);
		pins.drive(`PCID_PORT_E, 8'hff);
		repeat (8) @(posedge clock);
		rd(ra(3, 4'h8), `PCID_PORT_E_MASK);
		wr(ra(3, 4'h8), 8'h00);
		wr(ra(0, 4'h8), 8'h00);
		pins.doze(1'b1);
		w = wake_cnt;
		bump_a();
		chk(wake_cnt - w, 1);
		rd(ra(0, 4'h8), 8'h01);
		wr(`PCID_CTRL_OFF, 8'h00);
		w = wake_cnt;
		bump_a();
		chk(wake_cnt - w, 0);
		pins.doze(1'b0);
		rd(`PCID_EVT_STAT_OFF, 8'h03);
		rd(`PCID_EVT_STAT_OFF, 8'h00);
		wr(`PCID_EVT_MASK_OFF, 8'h01);
		chk(irq, 1'b0);
		bump_a();
		chk(irq, 1'b1);
		rd(`PCID_EVT_STAT_OFF, 8'h01);
		chk(irq, 1'b0);
		wr(`PCID_EVT_MASK_OFF, 8'h00);
		bump_a();
		chk(irq, 1'b0);
		rd(`PCID_EVT_STAT_OFF, 8'h01);
		summarize();
	end
endmodule
